// ===== logic/cmyk_video_pkg.sv
// Shared constants for the CMYK to RGB video pixel path
package cmyk_video_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CMD0 = 8'h02;
    localparam logic [7:0] IDX_CMD2 = 8'h04;
    localparam logic [7:0] IDX_LUT_INDEX = 8'h10;
    localparam logic [7:0] IDX_LUT_DATA = 8'h11;
    localparam int ADDR_W = 10;
    localparam int REG_W = 9;
    // Command register 0 fields
    localparam int VCLK_DIV_LO = 6;
    localparam int VCLK_DIV_HI = 7;
    // Command register 2 fields
    localparam int SYNC_ENCODE_BIT = 7;
    localparam int PEDESTAL_BIT = 6;
    localparam int SYNC_STATUS_BIT = 1;
    localparam int BLANK_STATUS_BIT = 0;
    localparam logic [8:0] CMD2_WRITE_MASK = 9'h1FC;
    // Reset values
    localparam logic [8:0] CMD0_RESET = 9'h000;
    localparam logic [8:0] CMD2_RESET = 9'h000;
    // Video clock: half period of the divide-by-4 setting, in MCLK cycles
    localparam logic [4:0] VCLK_HALF_MIN = 5'h02;
    // Table geometry and full-scale code
    localparam int LUT_DEPTH = 256;
    localparam int LUT_AW = 8;
    localparam int COMP_W = 8;
    localparam logic [7:0] FULL_SCALE = 8'hFF;
    // Control stages between sync/blank latch and output register
    localparam int CTL_STAGES = 3;
endpackage : cmyk_video_pkg

// ===== logic/black_sub_table.sv
// Host-loaded black-substitution lookup table with a registered read
`timescale 1ns/1ps
`default_nettype none
module black_sub_table (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [cmyk_video_pkg::LUT_AW-1:0] wr_index,
    input wire logic [cmyk_video_pkg::COMP_W-1:0] wr_data,
    input wire logic [cmyk_video_pkg::LUT_AW-1:0] rd_index,
    output logic [cmyk_video_pkg::COMP_W-1:0] rd_data
);
    // No reset and no preload: contents are undefined until software fills them
    logic [cmyk_video_pkg::COMP_W-1:0] mem [cmyk_video_pkg::LUT_DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_index] <= wr_data;
        end
        rd_data <= mem[rd_index];
    end
endmodule : black_sub_table
`default_nettype wire

// ===== logic/cmyk_rgb_video.sv
// CMYK to RGB pixel pipeline with video clock, sync/blank timing and registers
// Function
// - Per pixel, find min and max of C, M, Y and their difference.
// - Each of R, G, B is one minus its complement minus k.
// - Black substitution uses a 256 by 8 table indexed by the difference.
// - Index codes 00 to FF span the argument range zero to one.
// - Free-running video clock out, pixel clock divided by 4, 8, 16 or 32.
// - Sync and blank are sampled on each falling video clock edge.
// - Sync and blank timing comes only from those inputs, not pixel data.
// - First loaded pixel of a line is first shown; trailing ones may drop.
// - Delayed active-low sync output follows sync by the pipeline depth.
// - Pixel input to output latency is fixed.
// - Sync and blank travel with pixel data to shape the same pixel.
// - Command bits pick 0 or 7.5 IRE pedestal and sync on green.
// - With 0 IRE pedestal black and blank give the same level.
// - Blank low forces blank or sync; sync alone only drops sync current.
// - First command register at index 02, readable and writable anytime.
// - Divide field: 00 by 4, 01 by 8, 10 by 16, 11 by 32.
// - Sync enable low kills green sync, sync status and delayed sync pin.
// - Sync and blank status bits are read-only copies of output levels.
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module cmyk_rgb_video (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [cmyk_video_pkg::ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic [7:0] PIX_CYAN,
    input wire logic [7:0] PIX_MAGENTA,
    input wire logic [7:0] PIX_YELLOW,
    input wire logic [7:0] PIX_BLACK,
    input wire logic SYNC_N,
    input wire logic BLANK_N,
    output logic VIDEO_CLOCK_OUT_N,
    output logic DELAYED_SYNC_OUT_N,
    output logic [7:0] RED_OUTPUT,
    output logic [7:0] GREEN_OUTPUT,
    output logic [7:0] BLUE_OUTPUT,
    output logic GREEN_SYNC_ON,
    output logic PEDESTAL_ON,
    output logic BLANK_OUT_N
);
    typedef struct packed {
        logic [8:0] cmd0;
        logic [8:0] cmd2;
        logic [7:0] lut_index;
        logic wait_req;
        logic [31:0] rdata;
        logic [4:0] vcnt;
        logic vclk_n;
        logic sync_lat;
        logic blank_lat;
        logic [7:0] c1, m1, y1, k1in, xmax1;
        logic [7:0] c2, m2, y2, kmin2;
        logic [7:0] r3, g3, b3;
        logic [cmyk_video_pkg::CTL_STAGES-1:0] ctl_sync;
        logic [cmyk_video_pkg::CTL_STAGES-1:0] ctl_blank;
        logic [7:0] red, green, blue;
        logic green_sync;
        logic pedestal;
        logic dsync_n;
        logic blank_o_n;
        logic sync_st;
        logic blank_st;
    } state_s;

    state_s st;
    state_s next_st;
    logic lut_we;
    logic [7:0] lut_q;
    logic [7:0] xmin_in;
    logic [7:0] xmax_in;
    logic [7:0] diff_in;

    function automatic logic [7:0] min3(input logic [7:0] a, input logic [7:0] b,
                                        input logic [7:0] c);
        logic [7:0] t;
        t = (a < b) ? a : b;
        return (t < c) ? t : c;
    endfunction : min3

    function automatic logic [7:0] max3(input logic [7:0] a, input logic [7:0] b,
                                        input logic [7:0] c);
        logic [7:0] t;
        t = (a > b) ? a : b;
        return (t > c) ? t : c;
    endfunction : max3

    // Exact floor of p / 255 for any 8-bit by 8-bit product, without a divider
    function automatic logic [7:0] div255(input logic [15:0] p);
        logic [16:0] t;
        t = {1'b0, p} + {9'h000, p[15:8]} + 17'h00001;
        return t[15:8];
    endfunction : div255

    // One minus the complement minus k, floored at zero instead of wrapping
    function automatic logic [7:0] sub_clamp(input logic [7:0] comp, input logic [7:0] k);
        logic [8:0] t;
        t = {1'b0, cmyk_video_pkg::FULL_SCALE} - {1'b0, comp} - {1'b0, k};
        return t[8] ? 8'h00 : t[7:0];
    endfunction : sub_clamp

    function automatic logic [4:0] vclk_half(input logic [1:0] sel);
        return cmyk_video_pkg::VCLK_HALF_MIN << sel;
    endfunction : vclk_half

    assign xmin_in = min3(PIX_CYAN, PIX_MAGENTA, PIX_YELLOW);
    assign xmax_in = max3(PIX_CYAN, PIX_MAGENTA, PIX_YELLOW);
    assign diff_in = xmax_in - xmin_in;

    black_sub_table u_table (
        .clk(MCLK),
        .wr_en(lut_we),
        .wr_index(st.lut_index),
        .wr_data(AVS_WRITEDATA[7:0]),
        .rd_index(diff_in),
        .rd_data(lut_q)
    );

    always_comb begin
        logic [7:0] idx;
        logic take;
        logic [4:0] half;
        logic [7:0] k1v;
        logic [7:0] k2v;
        idx = 8'h00;
        take = 1'b0;
        half = 5'h00;
        k1v = 8'h00;
        k2v = 8'h00;
        next_st = st;
        lut_we = 1'b0;

        // Bus slave: waitrequest drops one cycle after a request, then the edge completes it
        idx = AVS_ADDRESS[cmyk_video_pkg::ADDR_W-1:2];
        take = (AVS_READ || AVS_WRITE) && !st.wait_req;
        next_st.wait_req = 1'b1;
        if ((AVS_READ || AVS_WRITE) && st.wait_req) begin
            next_st.wait_req = 1'b0;
            next_st.rdata = 32'h00000000;
            case (idx)
                cmyk_video_pkg::IDX_CMD0: next_st.rdata[8:0] = st.cmd0;
                cmyk_video_pkg::IDX_CMD2: begin
                    next_st.rdata[8:0] = st.cmd2;
                    next_st.rdata[cmyk_video_pkg::SYNC_STATUS_BIT] = st.sync_st;
                    next_st.rdata[cmyk_video_pkg::BLANK_STATUS_BIT] = st.blank_st;
                end
                cmyk_video_pkg::IDX_LUT_INDEX: next_st.rdata[7:0] = st.lut_index;
                default: next_st.rdata = 32'h00000000;
            endcase
        end
        if (take && AVS_WRITE) begin
            case (idx)
                cmyk_video_pkg::IDX_CMD0: begin
                    if (AVS_BYTEENABLE[0]) begin
                        next_st.cmd0[7:0] = AVS_WRITEDATA[7:0];
                    end
                    if (AVS_BYTEENABLE[1]) begin
                        next_st.cmd0[8] = AVS_WRITEDATA[8];
                    end
                end
                cmyk_video_pkg::IDX_CMD2: begin
                    // Status bits are masked off: writes to them have no effect
                    if (AVS_BYTEENABLE[0]) begin
                        next_st.cmd2[7:0] = AVS_WRITEDATA[7:0]
                            & cmyk_video_pkg::CMD2_WRITE_MASK[7:0];
                    end
                    if (AVS_BYTEENABLE[1]) begin
                        next_st.cmd2[8] = AVS_WRITEDATA[8];
                    end
                end
                cmyk_video_pkg::IDX_LUT_INDEX: begin
                    if (AVS_BYTEENABLE[0]) begin
                        next_st.lut_index = AVS_WRITEDATA[7:0];
                    end
                end
                cmyk_video_pkg::IDX_LUT_DATA: begin
                    // Auto-increment lets software stream all 256 entries in order
                    if (AVS_BYTEENABLE[0]) begin
                        lut_we = 1'b1;
                        next_st.lut_index = st.lut_index + 8'h01;
                    end
                end
                default: next_st.lut_index = st.lut_index;
            endcase
        end

        // Video clock divider; >= keeps it running if the field shrinks mid-count
        half = vclk_half(st.cmd0[cmyk_video_pkg::VCLK_DIV_HI:cmyk_video_pkg::VCLK_DIV_LO]);
        next_st.vcnt = st.vcnt + 5'h01;
        if (st.vcnt >= half - 5'h01) begin
            next_st.vcnt = 5'h00;
            next_st.vclk_n = !st.vclk_n;
            if (st.vclk_n) begin
                next_st.sync_lat = SYNC_N;
                next_st.blank_lat = BLANK_N;
            end
        end

        // Stage 1: components, max and table lookup in flight
        next_st.c1 = PIX_CYAN;
        next_st.m1 = PIX_MAGENTA;
        next_st.y1 = PIX_YELLOW;
        next_st.k1in = PIX_BLACK;
        next_st.xmax1 = xmax_in;
        // Stage 2: k is the lesser of 1 - xmax and K * f(d)
        k1v = cmyk_video_pkg::FULL_SCALE - st.xmax1;
        // Zero black skips the product, so an unloaded table cannot spoil white pixels
        k2v = (st.k1in == 8'h00) ? 8'h00
            : div255(16'(st.k1in) * 16'(lut_q));
        next_st.kmin2 = (k1v < k2v) ? k1v : k2v;
        next_st.c2 = st.c1;
        next_st.m2 = st.m1;
        next_st.y2 = st.y1;
        // Stage 3: colour results, clamped
        next_st.r3 = sub_clamp(st.c2, st.kmin2);
        next_st.g3 = sub_clamp(st.m2, st.kmin2);
        next_st.b3 = sub_clamp(st.y2, st.kmin2);

        // Sync and blank ride alongside the three pixel stages
        next_st.ctl_sync = {st.ctl_sync[cmyk_video_pkg::CTL_STAGES-2:0], st.sync_lat};
        next_st.ctl_blank = {st.ctl_blank[cmyk_video_pkg::CTL_STAGES-2:0], st.blank_lat};

        // Output stage: fixed depth, so latency never varies
        if (st.ctl_blank[cmyk_video_pkg::CTL_STAGES-1]) begin
            next_st.red = st.r3;
            next_st.green = st.g3;
            next_st.blue = st.b3;
        end else begin
            next_st.red = 8'h00;
            next_st.green = 8'h00;
            next_st.blue = 8'h00;
        end
        next_st.blank_o_n = st.ctl_blank[cmyk_video_pkg::CTL_STAGES-1];
        next_st.pedestal = st.ctl_blank[cmyk_video_pkg::CTL_STAGES-1]
            && st.cmd2[cmyk_video_pkg::PEDESTAL_BIT];
        next_st.green_sync = st.cmd2[cmyk_video_pkg::SYNC_ENCODE_BIT]
            && !st.ctl_sync[cmyk_video_pkg::CTL_STAGES-1];
        next_st.dsync_n = !st.cmd2[cmyk_video_pkg::SYNC_ENCODE_BIT]
            || st.ctl_sync[cmyk_video_pkg::CTL_STAGES-1];
        next_st.sync_st = st.cmd2[cmyk_video_pkg::SYNC_ENCODE_BIT]
            && !st.ctl_sync[cmyk_video_pkg::CTL_STAGES-1];
        next_st.blank_st = !st.ctl_blank[cmyk_video_pkg::CTL_STAGES-1];
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            st <= '0;
            st.cmd0 <= cmyk_video_pkg::CMD0_RESET;
            st.cmd2 <= cmyk_video_pkg::CMD2_RESET;
            st.wait_req <= 1'b1;
            st.vclk_n <= 1'b1;
            st.sync_lat <= 1'b1;
            st.blank_lat <= 1'b0;
            st.green_sync <= 1'b0;
            st.dsync_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign AVS_READDATA = st.rdata;
    assign AVS_WAITREQUEST = st.wait_req;
    assign VIDEO_CLOCK_OUT_N = st.vclk_n;
    assign DELAYED_SYNC_OUT_N = st.dsync_n;
    assign RED_OUTPUT = st.red;
    assign GREEN_OUTPUT = st.green;
    assign BLUE_OUTPUT = st.blue;
    assign GREEN_SYNC_ON = st.green_sync;
    assign PEDESTAL_ON = st.pedestal;
    assign BLANK_OUT_N = st.blank_o_n;

    a_bus_answers: assert property (@(posedge MCLK) disable iff (RST)
        ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST)
        else $error("Bus request not answered in one cycle");

    a_blank_zeroes_data: assert property (@(posedge MCLK) disable iff (RST)
        !BLANK_OUT_N |-> (RED_OUTPUT == 8'h00 && GREEN_OUTPUT == 8'h00
                          && BLUE_OUTPUT == 8'h00 && !PEDESTAL_ON))
        else $error("Blanked output carries data");

    a_sync_pin_off: assert property (@(posedge MCLK) disable iff (RST)
        !$past(st.cmd2[cmyk_video_pkg::SYNC_ENCODE_BIT])
            |-> (DELAYED_SYNC_OUT_N && !GREEN_SYNC_ON && !st.sync_st))
        else $error("Sync seen while sync encode disabled");

    a_blank_latency: assert property (@(posedge MCLK) disable iff (RST)
        $fell(st.blank_lat) |-> ##4 !BLANK_OUT_N)
        else $error("Blank not delayed by four cycles");

    a_white_pixel: assert property (@(posedge MCLK) disable iff (RST)
        (PIX_CYAN == 8'h00 && PIX_MAGENTA == 8'h00 && PIX_YELLOW == 8'h00
         && PIX_BLACK == 8'h00) |-> ##3 (st.r3 == 8'hFF && st.g3 == 8'hFF))
        else $error("Zero CMYK does not give white");

    a_full_cyan_clamp: assert property (@(posedge MCLK) disable iff (RST)
        (PIX_CYAN == 8'hFF) |-> ##3 (st.r3 == 8'h00))
        else $error("Full cyan leaves red above zero");

    a_vclk_div_four: assert property (@(posedge MCLK) disable iff (RST)
        ($fell(VIDEO_CLOCK_OUT_N) && st.cmd0[7:6] == 2'b00 && $past(st.cmd0[7:6]) == 2'b00)
            |-> !VIDEO_CLOCK_OUT_N ##1 !VIDEO_CLOCK_OUT_N ##1 VIDEO_CLOCK_OUT_N)
        else $error("Video clock low phase not two cycles");

    a_zero_pedestal: assert property (@(posedge MCLK) disable iff (RST)
        !st.cmd2[cmyk_video_pkg::PEDESTAL_BIT] |=> !PEDESTAL_ON)
        else $error("Pedestal on while 0 IRE selected");
endmodule : cmyk_rgb_video
`default_nettype wire

// ===== tb/video_timing_model.sv
// Display timing generator model driving composite sync and blank
`timescale 1ns/1ps
`default_nettype none
module video_timing_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic vclk_n,
    input wire logic want_sync_n,
    input wire logic want_blank_n,
    output logic sync_n,
    output logic blank_n
);
    logic vclk_prev;
    // Change one cycle after the video clock rises, well clear of the sampling fall
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vclk_prev <= 1'b1;
            sync_n <= 1'b1;
            blank_n <= 1'b1;
        end else begin
            vclk_prev <= vclk_n;
            if (vclk_n && !vclk_prev) begin
                sync_n <= want_sync_n;
                blank_n <= want_blank_n;
            end
        end
    end
endmodule : video_timing_model
`default_nettype wire

// ===== tb/cmyk_rgb_video_tb.sv
// Self-checking testbench for the CMYK to RGB video pipeline
`timescale 1ns/1ps
`default_nettype none
module cmyk_rgb_video_tb;
    logic MCLK = 1'b0;
    logic RST = 1'b1;
    logic [9:0] AVS_ADDRESS = 10'h000;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic [3:0] AVS_BYTEENABLE = 4'h0;
    logic [31:0] AVS_READDATA;
    logic AVS_WAITREQUEST, VIDEO_CLOCK_OUT_N, DELAYED_SYNC_OUT_N, SYNC_N, BLANK_N;
    logic [7:0] PIX_CYAN = 8'h00, PIX_MAGENTA = 8'h00, PIX_YELLOW = 8'h00, PIX_BLACK = 8'h00;
    logic [7:0] RED_OUTPUT, GREEN_OUTPUT, BLUE_OUTPUT;
    logic GREEN_SYNC_ON, PEDESTAL_ON, BLANK_OUT_N;
    logic want_sync_n = 1'b1;
    logic want_blank_n = 1'b1;
    int err_total = 0;
    int checks_done = 0;
    logic [31:0] pix_tab [4] = '{32'h00000000, 32'hFFFFFFFF, 32'h208040FF, 32'h10302040};
    localparam logic [31:0] PIX_A = 32'h208040FF;

    always #10 MCLK = ~MCLK;

    cmyk_rgb_video dut_u (.MCLK(MCLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .PIX_CYAN(PIX_CYAN), .PIX_MAGENTA(PIX_MAGENTA),
        .PIX_YELLOW(PIX_YELLOW), .PIX_BLACK(PIX_BLACK), .SYNC_N(SYNC_N), .BLANK_N(BLANK_N),
        .VIDEO_CLOCK_OUT_N(VIDEO_CLOCK_OUT_N), .DELAYED_SYNC_OUT_N(DELAYED_SYNC_OUT_N),
        .RED_OUTPUT(RED_OUTPUT), .GREEN_OUTPUT(GREEN_OUTPUT), .BLUE_OUTPUT(BLUE_OUTPUT),
        .GREEN_SYNC_ON(GREEN_SYNC_ON), .PEDESTAL_ON(PEDESTAL_ON), .BLANK_OUT_N(BLANK_OUT_N));

    video_timing_model timing_u (.clk(MCLK), .rst(RST), .vclk_n(VIDEO_CLOCK_OUT_N),
        .want_sync_n(want_sync_n), .want_blank_n(want_blank_n), .sync_n(SYNC_N),
        .blank_n(BLANK_N));

    function automatic logic [7:0] clamp8(input int v);
        return (v < 0) ? 8'h00 : v[7:0];
    endfunction : clamp8

    // Table is loaded with 255 minus the index, so f(d) = 255 - d
    function automatic logic [23:0] rgb_of(input logic [31:0] p);
        int c, m, y, kb, xmax, xmin, k1, k2, k;
        {c, m, y, kb} = {24'h0, p[31:24], 24'h0, p[23:16], 24'h0, p[15:8], 24'h0, p[7:0]};
        xmax = (c > m) ? c : m;
        xmax = (y > xmax) ? y : xmax;
        xmin = (c < m) ? c : m;
        xmin = (y < xmin) ? y : xmin;
        k1 = 255 - xmax;
        k2 = (kb * (255 - (xmax - xmin))) / 255;
        k = (k1 < k2) ? k1 : k2;
        return {clamp8(255 - c - k), clamp8(255 - m - k), clamp8(255 - y - k)};
    endfunction : rgb_of

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // One Avalon transfer; held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [8:0] wd,
                       output logic [31:0] rd);
        @(posedge MCLK);
        AVS_ADDRESS <= {idx, 2'b00};
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        AVS_WRITEDATA <= {23'h0, wd};
        AVS_BYTEENABLE <= 4'hF;
        // No cycle limit here: a slave that never answers is cut off by the watchdog
        do begin
            @(posedge MCLK);
        end while (AVS_WAITREQUEST !== 1'b0);
        rd = AVS_READDATA;
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
    endtask : bus

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input string what);
        logic [31:0] rd;
        bus(1'b0, idx, 9'h000, rd);
        chk(rd, exp, what);
    endtask : rd_chk

    task automatic wr(input logic [7:0] idx, input logic [8:0] wd);
        logic [31:0] rd;
        bus(1'b1, idx, wd, rd);
    endtask : wr

    task automatic set_pix(input logic [31:0] p);
        @(posedge MCLK);
        {PIX_CYAN, PIX_MAGENTA, PIX_YELLOW, PIX_BLACK} <= p;
    endtask : set_pix

    // Flags are blank_n, delayed sync_n, green sync, pedestal
    task automatic outs_are(input logic [23:0] rgb, input logic [3:0] fl, input string what);
        chk({4'h0, RED_OUTPUT, GREEN_OUTPUT, BLUE_OUTPUT, BLANK_OUT_N, DELAYED_SYNC_OUT_N,
             GREEN_SYNC_ON, PEDESTAL_ON}, {4'h0, rgb, fl}, what);
    endtask : outs_are

    task automatic fall_gap(output int n);
        logic p;
        n = 0;
        p = VIDEO_CLOCK_OUT_N;
        repeat (100) begin
            @(posedge MCLK);
            n++;
            if (p === 1'b1 && VIDEO_CLOCK_OUT_N === 1'b0) break;
            p = VIDEO_CLOCK_OUT_N;
        end
    endtask : fall_gap

    task automatic test_regs();
        // Blank status stays set until the first latched blank level crosses the pipeline
        repeat (8) @(posedge MCLK);
        rd_chk(cmyk_video_pkg::IDX_CMD0, 32'h0, "cmd0 reset");
        rd_chk(cmyk_video_pkg::IDX_CMD2, 32'h0, "cmd2 reset");
        wr(cmyk_video_pkg::IDX_CMD0, 9'h1C5);
        rd_chk(cmyk_video_pkg::IDX_CMD0, 32'h1C5, "cmd0 rw");
        wr(8'hFF, 9'h1FF);
        rd_chk(8'hFF, 32'h0, "unmapped");
        wr(cmyk_video_pkg::IDX_CMD0, 9'h000);
    endtask : test_regs

    task automatic test_vclk();
        int n;
        for (int d = 0; d < 4; d++) begin
            wr(cmyk_video_pkg::IDX_CMD0, 9'(d << 6));
            fall_gap(n);
            fall_gap(n);
            chk(32'(n), 32'(4 << d), "video clock period");
        end
        wr(cmyk_video_pkg::IDX_CMD0, 9'h000);
    endtask : test_vclk

    task automatic test_conv();
        wr(cmyk_video_pkg::IDX_LUT_INDEX, 9'h000);
        for (int i = 0; i < 256; i++) wr(cmyk_video_pkg::IDX_LUT_DATA, 9'(255 - i));
        foreach (pix_tab[i]) begin
            set_pix(pix_tab[i]);
            repeat (8) @(posedge MCLK);
            outs_are(rgb_of(pix_tab[i]), 4'hC, "colour");
        end
        // Latency: new pixel shows exactly after the fourth edge past the drive edge
        set_pix(32'h0);
        repeat (8) @(posedge MCLK);
        set_pix(PIX_A);
        repeat (4) @(posedge MCLK);
        outs_are(24'hFFFFFF, 4'hC, "latency early");
        @(posedge MCLK);
        outs_are(rgb_of(PIX_A), 4'hC, "latency");
    endtask : test_conv

    task automatic test_video();
        wr(cmyk_video_pkg::IDX_CMD2, 9'h0C3);
        repeat (60) @(posedge MCLK);
        rd_chk(cmyk_video_pkg::IDX_CMD2, 32'h0C0, "status idle");
        outs_are(rgb_of(PIX_A), 4'hD, "pedestal");
        want_sync_n <= 1'b0;
        want_blank_n <= 1'b0;
        repeat (60) @(posedge MCLK);
        rd_chk(cmyk_video_pkg::IDX_CMD2, 32'h0C3, "status sync");
        outs_are(24'h0, 4'h2, "sync blank");
        wr(cmyk_video_pkg::IDX_CMD2, 9'h040);
        repeat (10) @(posedge MCLK);
        rd_chk(cmyk_video_pkg::IDX_CMD2, 32'h041, "sync off status");
        outs_are(24'h0, 4'h4, "sync off");
        want_blank_n <= 1'b1;
        repeat (60) @(posedge MCLK);
        outs_are(rgb_of(PIX_A), 4'hD, "data sync off");
        wr(cmyk_video_pkg::IDX_CMD2, 9'h080);
        repeat (10) @(posedge MCLK);
        outs_are(rgb_of(PIX_A), 4'hA, "data sync");
        want_sync_n <= 1'b1;
        set_pix(32'hFFFFFF00);
        repeat (60) @(posedge MCLK);
        outs_are(24'h0, 4'hC, "black as blank");
    endtask : test_video

    task automatic close_out();
        $display("errors %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out

    // Whole run needs about 1300 cycles; a hang is cut off well beyond that
    initial begin
        repeat (20000) @(posedge MCLK);
        err_total++;
        close_out();
    end

    initial begin
        repeat (16) @(posedge MCLK);
        RST <= 1'b0;
        test_regs();
        test_vclk();
        test_conv();
        test_video();
        close_out();
    end
endmodule : cmyk_rgb_video_tb
`default_nettype wire
